/* File: logic/lct_pin_sync.sv */
// three-stage pin synchroniser turning an external clock into a rise pulse
`timescale 1ns/1ns
module lct_pin_sync
    import lct_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pin side
    input  wire logic pin_i,
    // clock domain side
    output logic      level_o,
    output logic      rise_o
);

    logic s1;
    logic s2;
    logic s3;

    // s1 feeds s2 only; the level moves once s2 and s3 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= 1'h0;
            s2 <= 1'h0;
            s3 <= 1'h0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'h0;
            rise_o  <= 1'h0;
        end else begin
            rise_o <= 1'h0;
            if (s2 == s3 && s3 != level_o) begin
                level_o <= s3;
                rise_o  <= s3;
            end
        end
    end

endmodule

/* File: logic/lct_pkg.sv */
// shared constants, field layout and types for the clock tree and modulator
package lct_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus and register map
    localparam int          ADR_W      = 8;
    localparam int          DAT_W      = 32;
    localparam int          SEL_W      = 4;
    localparam int          BYTE_W     = 8;
    localparam logic [7:0]  OFS_CLKDIV = 8'h00;
    localparam logic [7:0]  OFS_PIXCFG = 8'h04;
    localparam logic [7:0]  OFS_PWMCFG = 8'h08;
    localparam logic [7:0]  OFS_STATUS = 8'h0C;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

    // writable bits of each configuration register; everything else reads as zero
    localparam logic [31:0] MASK_CLKDIV = 32'h0000_FFFF;
    localparam logic [31:0] MASK_PIXCFG = 32'h0000_FF03;
    localparam logic [31:0] MASK_PWMCFG = 32'h00FF_FF0F;

    // all configuration resets to zero: divide by one, sources at input 0,
    // modulator off, force-high off
    localparam logic [31:0] RST_CLKDIV = 32'h0000_0000;
    localparam logic [31:0] RST_PIXCFG = 32'h0000_0000;
    localparam logic [31:0] RST_PWMCFG = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int DIV_W         = 8;
    localparam int SRC_W         = 2;
    localparam int DUTY_W        = 8;
    localparam int BUS_DIV_LSB   = 0;
    localparam int MEM_DIV_LSB   = 8;
    localparam int PIX_SRC_LSB   = 0;
    localparam int PIX_DIV_LSB   = 8;
    localparam int PWM_EN_BIT    = 0;
    localparam int PWM_FORCE_BIT = 1;
    localparam int PWM_SRC_LSB   = 2;
    localparam int PWM_DIV_LSB   = 8;
    localparam int PWM_DUTY_LSB  = 16;
    localparam int ST_PWM_BIT    = 0;
    localparam int ST_PRIM_BIT   = 1;
    localparam int ST_SEC_BIT    = 2;
    localparam int ST_FRAME_LSB  = 8;

    localparam logic [DIV_W-1:0]  DIV_ZERO   = 8'h00;
    localparam logic [DIV_W-1:0]  DIV_ONE    = 8'h01;
    localparam logic [DUTY_W-1:0] FRAME_ZERO = 8'h00;
    localparam logic [DUTY_W-1:0] FRAME_ONE  = 8'h01;
    localparam logic [DUTY_W-1:0] FRAME_LAST = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // source selections
    typedef enum logic [SRC_W-1:0] {
        PIX_SRC_PRIM = 2'h0,
        PIX_SRC_SEC  = 2'h1,
        PIX_SRC_BUS  = 2'h2,
        PIX_SRC_MEM  = 2'h3
    } lct_pix_src_t;

    typedef enum logic [SRC_W-1:0] {
        PWM_SRC_PRIM = 2'h0,
        PWM_SRC_SEC  = 2'h1,
        PWM_SRC_MEM  = 2'h2,
        PWM_SRC_PIX  = 2'h3
    } lct_pwm_src_t;

    // one-cycle rate enables of every clock in the tree
    typedef struct packed {
        logic prim;
        logic sec;
        logic bus;
        logic mem;
        logic pix;
        logic pwm;
    } lct_ticks_t;

endpackage

/* File: logic/lct_tick_div.sv */
// programmable divider of a one-cycle rate enable, ratio div_i + 1
`timescale 1ns/1ns
module lct_tick_div
    import lct_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             en_i,
    input  wire logic [DIV_W-1:0] div_i,
    // rates
    input  wire logic             tick_i,
    output logic                  tick_o
);

    logic [DIV_W-1:0] cnt;

    // >= rather than == so lowering the ratio mid-count never runs 256 extra ticks
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            cnt    <= DIV_ZERO;
            tick_o <= 1'h0;
        end else if (tick_i) begin
            if (cnt >= div_i) begin
                cnt    <= DIV_ZERO;
                tick_o <= 1'h1;
            end else begin
                cnt    <= cnt + DIV_ONE;
                tick_o <= 1'h0;
            end
        end else begin
            tick_o <= 1'h0;
        end
    end

endmodule

/* File: logic/lct_top.sv */
// clock tree with source selection, dividers and the pulse width modulator
// Summary of operation
// (R1) the pixel clock source is chosen from primary input, secondary input, bus or memory clock.
// (R2) the pixel clock is its selected source divided by a programmable ratio.
// (R3) the bus interface clock always comes from the primary clock input.
// (R4) the bus interface clock is the primary input divided by a programmable ratio.
// (R5) the memory clock always comes from the bus interface clock, so it scales with it.
// (R6) the memory clock is the bus interface clock divided by a programmable ratio.
// (R7) software keeps the memory divider at one unless that exceeds 50 MHz, aiming near 50 MHz.
// (R8) the modulator base clock logic runs only while its enable is set.
// (R9) force-high drives the modulator output high whatever the enable or duty.
// (R10) without force-high the output is low when disabled and follows the duty when enabled.
// (R11) the modulator source is chosen from primary input, secondary input, memory or pixel clock.
// (R12) the modulator source is divided by a programmable ratio and then by a fixed 256.
// (R13) in each frame of 256 modulator periods the output is high for the duty count of periods.
// (R14) one free-running 8-bit counter gives the 256 division and the duty compare (high below).
// (R15) after reset every divider is one and the modulator is off with force-high clear.
`timescale 1ns/1ns
module lct_top
    import lct_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [SEL_W-1:0] wb_sel_i,
    input  wire logic [DAT_W-1:0] wb_dat_i,
    output logic      [DAT_W-1:0] wb_dat_o,
    output logic                  wb_ack_o,
    // external clock pins
    input  wire logic             primary_clock_input_i,
    input  wire logic             secondary_clock_input_i,
    // derived rate enables
    output logic                  bus_clk_en_o,
    output logic                  mem_clk_en_o,
    output logic                  pix_clk_en_o,
    output logic                  pwm_clk_en_o,
    // modulator
    output logic                  pwm_output_o
);

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers and decoded fields

    logic [DAT_W-1:0]  reg_clkdiv;
    logic [DAT_W-1:0]  reg_pixcfg;
    logic [DAT_W-1:0]  reg_pwmcfg;
    logic [DIV_W-1:0]  bus_div;
    logic [DIV_W-1:0]  mem_div;
    logic [DIV_W-1:0]  pix_div;
    logic [DIV_W-1:0]  pwm_div;
    logic [DUTY_W-1:0] pwm_duty;
    lct_pix_src_t      pix_src;
    lct_pwm_src_t      pwm_src;
    logic              pwm_en;
    logic              pwm_force;
    logic              prim_level;
    logic              sec_level;
    logic [DUTY_W-1:0] frame_cnt;
    lct_ticks_t        ticks;
    logic              pix_src_tick;
    logic              pwm_src_tick;
    logic              bus_req;
    logic              wr_take;
    logic [DAT_W-1:0]  next_rd_data;

    assign bus_div   = reg_clkdiv[BUS_DIV_LSB +: DIV_W];
    assign mem_div   = reg_clkdiv[MEM_DIV_LSB +: DIV_W];
    assign pix_div   = reg_pixcfg[PIX_DIV_LSB +: DIV_W];
    assign pix_src   = lct_pix_src_t'(reg_pixcfg[PIX_SRC_LSB +: SRC_W]);
    assign pwm_en    = reg_pwmcfg[PWM_EN_BIT];
    assign pwm_force = reg_pwmcfg[PWM_FORCE_BIT];
    assign pwm_src   = lct_pwm_src_t'(reg_pwmcfg[PWM_SRC_LSB +: SRC_W]);
    assign pwm_div   = reg_pwmcfg[PWM_DIV_LSB +: DIV_W];
    assign pwm_duty  = reg_pwmcfg[PWM_DUTY_LSB +: DUTY_W];

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after the request, writes at the ack edge

    function automatic logic [DAT_W-1:0] merge_bytes(
        input logic [DAT_W-1:0] old_v,
        input logic [DAT_W-1:0] new_v,
        input logic [SEL_W-1:0] sel,
        input logic [DAT_W-1:0] mask
    );
        logic [DAT_W-1:0] res;
        res = old_v;
        for (int b = 0; b < SEL_W; b++) begin
            if (sel[b]) begin
                res[b*BYTE_W +: BYTE_W] = new_v[b*BYTE_W +: BYTE_W];
            end
        end
        return res & mask;
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // the master samples ack at this edge, so the write lands exactly then
    assign wr_take = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

    always_comb begin
        next_rd_data = ZERO_WORD;
        unique case (wb_adr_i)
            OFS_CLKDIV: next_rd_data = reg_clkdiv;
            OFS_PIXCFG: next_rd_data = reg_pixcfg;
            OFS_PWMCFG: next_rd_data = reg_pwmcfg;
            OFS_STATUS: begin
                next_rd_data[ST_PWM_BIT]                   = pwm_output_o;
                next_rd_data[ST_PRIM_BIT]                  = prim_level;
                next_rd_data[ST_SEC_BIT]                   = sec_level;
                next_rd_data[ST_FRAME_LSB +: DUTY_W]       = frame_cnt;
            end
            default: next_rd_data = ZERO_WORD;
        endcase
    end

    // unmapped addresses still ack, reading zero and dropping writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= ZERO_WORD;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? next_rd_data : ZERO_WORD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_clkdiv <= RST_CLKDIV; // [R15]
            reg_pixcfg <= RST_PIXCFG; // [R15]
            reg_pwmcfg <= RST_PWMCFG; // [R15]
        end else if (wr_take) begin
            unique case (wb_adr_i)
                OFS_CLKDIV: reg_clkdiv <= merge_bytes(reg_clkdiv, wb_dat_i, wb_sel_i, MASK_CLKDIV);
                OFS_PIXCFG: reg_pixcfg <= merge_bytes(reg_pixcfg, wb_dat_i, wb_sel_i, MASK_PIXCFG);
                OFS_PWMCFG: reg_pwmcfg <= merge_bytes(reg_pwmcfg, wb_dat_i, wb_sel_i, MASK_PWMCFG);
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external clocks become rise pulses on the system clock

    lct_pin_sync u_prim_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (primary_clock_input_i),
        .level_o (prim_level),
        .rise_o  (ticks.prim)
    );

    lct_pin_sync u_sec_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (secondary_clock_input_i),
        .level_o (sec_level),
        .rise_o  (ticks.sec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus and memory clocks: fixed sources, programmable ratios

    lct_tick_div u_bus_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (1'h1),
        .div_i  (bus_div),
        .tick_i (ticks.prim), // [R3]
        .tick_o (ticks.bus)   // [R4]
    );

    lct_tick_div u_mem_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (1'h1),
        .div_i  (mem_div),
        .tick_i (ticks.bus), // [R5]
        .tick_o (ticks.mem)  // [R6]
    );

    ////////////////////////////////////////////////////////////////////////////
    // pixel clock

    always_comb begin
        unique case (pix_src) // [R1]
            PIX_SRC_PRIM: pix_src_tick = ticks.prim;
            PIX_SRC_SEC:  pix_src_tick = ticks.sec;
            PIX_SRC_BUS:  pix_src_tick = ticks.bus;
            PIX_SRC_MEM:  pix_src_tick = ticks.mem;
        endcase
    end

    lct_tick_div u_pix_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (1'h1),
        .div_i  (pix_div),
        .tick_i (pix_src_tick),
        .tick_o (ticks.pix) // [R2]
    );

    ////////////////////////////////////////////////////////////////////////////
    // modulator base clock, gated by its enable

    always_comb begin
        unique case (pwm_src) // [R11]
            PWM_SRC_PRIM: pwm_src_tick = ticks.prim;
            PWM_SRC_SEC:  pwm_src_tick = ticks.sec;
            PWM_SRC_MEM:  pwm_src_tick = ticks.mem;
            PWM_SRC_PIX:  pwm_src_tick = ticks.pix;
        endcase
    end

    // disabling clears the divider so a re-enable starts a clean period
    lct_tick_div u_pwm_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (pwm_en), // [R8]
        .div_i  (pwm_div),
        .tick_i (pwm_src_tick),
        .tick_o (ticks.pwm) // [R12]
    );

    // one counter is both the fixed 256 divider and the duty reference
    always_ff @(posedge clk_i) begin
        if (rst_i || !pwm_en) begin
            frame_cnt <= FRAME_ZERO; // [R8]
        end else if (ticks.pwm) begin
            frame_cnt <= frame_cnt + FRAME_ONE; // [R12] [R14]
        end
    end

    // duty 0 keeps the line low; 255 is the widest pulse short of force-high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_output_o <= 1'h0; // [R15]
        end else if (pwm_force) begin
            pwm_output_o <= 1'h1; // [R9]
        end else if (!pwm_en) begin
            pwm_output_o <= 1'h0; // [R10]
        end else begin
            pwm_output_o <= (frame_cnt < pwm_duty); // [R10] [R13] [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rate enable outputs, registered once more so each leaves from a flop

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_clk_en_o <= 1'h0;
            mem_clk_en_o <= 1'h0;
            pix_clk_en_o <= 1'h0;
            pwm_clk_en_o <= 1'h0;
        end else begin
            bus_clk_en_o <= ticks.bus;
            mem_clk_en_o <= ticks.mem;
            pix_clk_en_o <= ticks.pix;
            pwm_clk_en_o <= ticks.pwm;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    a_bus_from_prim: assert property ( // [R3]
        @(posedge clk_i) disable iff (rst_i)
        ticks.bus |-> $past(ticks.prim))
        else $error("bus clock ticked without a primary input edge");

    a_bus_div_one: assert property ( // [R4]
        @(posedge clk_i) disable iff (rst_i)
        (ticks.prim && bus_div == DIV_ZERO && !$past(rst_i)) |=> ticks.bus)
        else $error("bus divider at one missed a primary edge");

    a_mem_from_bus: assert property ( // [R5]
        @(posedge clk_i) disable iff (rst_i)
        ticks.mem |-> $past(ticks.bus))
        else $error("memory clock ticked without a bus clock tick");

    a_mem_div_one: assert property ( // [R6]
        @(posedge clk_i) disable iff (rst_i)
        (ticks.bus && mem_div == DIV_ZERO) |=> ticks.mem)
        else $error("memory divider at one missed a bus tick");

    a_pix_src_mem: assert property ( // [R1]
        @(posedge clk_i) disable iff (rst_i)
        (pix_src == PIX_SRC_MEM && pix_div == DIV_ZERO && ticks.mem) |=> ticks.pix)
        else $error("pixel clock did not follow the memory clock");

    a_pix_div_two: assert property ( // [R2]
        @(posedge clk_i) disable iff (rst_i)
        (pix_div == DIV_ONE && $stable(pix_div) && ticks.pix) |-> !$past(ticks.pix, 2))
        else $error("pixel divider by two ticked on consecutive source edges");

    a_pwm_src_pix: assert property ( // [R11]
        @(posedge clk_i) disable iff (rst_i)
        (pwm_en && pwm_src == PWM_SRC_PIX && pwm_div == DIV_ZERO && ticks.pix
         && $past(pwm_en)) |=> ticks.pwm)
        else $error("modulator clock did not follow the pixel clock");

    a_pwm_off_quiet: assert property ( // [R8]
        @(posedge clk_i) disable iff (rst_i)
        !pwm_en |=> (!ticks.pwm && frame_cnt == FRAME_ZERO))
        else $error("modulator clock logic active while disabled");

    a_frame_wrap: assert property ( // [R12]
        @(posedge clk_i) disable iff (rst_i)
        (pwm_en && ticks.pwm && frame_cnt == FRAME_LAST) ##1 pwm_en
        |-> frame_cnt == FRAME_ZERO)
        else $error("modulator frame did not wrap after 256 periods");

    a_pwm_force_high: assert property ( // [R9]
        @(posedge clk_i) disable iff (rst_i)
        pwm_force |=> pwm_output_o)
        else $error("force-high did not drive the output high");

    a_pwm_idle_low: assert property ( // [R10]
        @(posedge clk_i) disable iff (rst_i)
        (!pwm_force && !pwm_en) [*2] |-> !pwm_output_o)
        else $error("output not low while modulator disabled");

    a_pwm_duty_cmp: assert property ( // [R13]
        @(posedge clk_i) disable iff (rst_i)
        (pwm_en && !pwm_force) |=> pwm_output_o == ($past(frame_cnt) < $past(pwm_duty)))
        else $error("output does not match the duty compare");

    a_reset_defaults: assert property ( // [R15]
        @(posedge clk_i)
        rst_i |=> (!pwm_output_o && !pwm_en && !pwm_force && bus_div == DIV_ZERO
                   && mem_div == DIV_ZERO && pix_div == DIV_ZERO
                   && pwm_div == DIV_ZERO))
        else $error("configuration not at defaults after reset");

    a_bus_ack_once: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

endmodule

/* File: tb/lct_pin_clk.sv */
// free-running model of an external clock source driving one clock pin
`timescale 1ns/1ns
module lct_pin_clk #(
    parameter int HALF_NS = 20
) (
    // pin
    output logic clk_o
);
    // a half period that is a multiple of 4 ns keeps pin edges off the
    // rising edges of the system clock, so the synchroniser never races
    initial clk_o = 1'b0;
    always #(HALF_NS) clk_o = ~clk_o;
endmodule

/* File: tb/lct_top_tb.sv */
// self-checking bench for the clock tree and the pulse width modulator
`timescale 1ns/1ns
module lct_top_tb
    import lct_pkg::*;
;
    typedef struct {
        logic [7:0]  adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic [31:0] exp;
    } lct_reg_row_t;
    typedef struct {
        logic [7:0]  adr;
        logic [31:0] dat;
        int          idx;
        int          per;
    } lct_rate_row_t;

    logic             clk_i    = 1'b0;
    logic             rst_i    = 1'b1;
    logic             wb_cyc   = 1'b0;
    logic             wb_stb   = 1'b0;
    logic             wb_we    = 1'b0;
    logic [ADR_W-1:0] wb_adr   = 8'h00;
    logic [SEL_W-1:0] wb_sel   = 4'h0;
    logic [DAT_W-1:0] wb_wdat  = 32'h0000_0000;
    logic [DAT_W-1:0] wb_dat_o;
    logic             wb_ack_o;
    logic             prim_pin;
    logic             sec_pin;
    logic             bus_clk_en_o;
    logic             mem_clk_en_o;
    logic             pix_clk_en_o;
    logic             pwm_clk_en_o;
    logic             pwm_output_o;
    logic [3:0]       ticks;
    int               num_errors = 0;
    int               cmp_count  = 0;

    // primary pin period 10 cycles, secondary 14 cycles
    lct_reg_row_t  reg_rows [7] = '{
        '{8'h00, 32'hFFFF_FFFF, 4'hF, 32'h0000_FFFF},
        '{8'h04, 32'hFFFF_FFFF, 4'hF, 32'h0000_FF03},
        '{8'h08, 32'hA5A5_A5A5, 4'h2, 32'h0000_A500},
        '{8'h10, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
        '{8'h00, 32'h0000_0000, 4'hF, 32'h0000_0000},
        '{8'h04, 32'h0000_0000, 4'hF, 32'h0000_0000},
        '{8'h08, 32'h0000_0000, 4'hF, 32'h0000_0000}};
    // the memory divider goes back to one right after its own check: the
    // undivided memory rate here is far below the memory clock ceiling
    lct_rate_row_t rate_rows [12] = '{
        '{8'h00, 32'h0000_0002, 0, 30},
        '{8'h00, 32'h0000_0102, 1, 60},
        '{8'h00, 32'h0000_0002, 1, 30},
        '{8'h04, 32'h0000_0001, 2, 14},
        '{8'h04, 32'h0000_0002, 2, 30},
        '{8'h04, 32'h0000_0003, 2, 30},
        '{8'h04, 32'h0000_0100, 2, 20},
        '{8'h04, 32'h0000_0300, 2, 40},
        '{8'h08, 32'h0000_0101, 3, 20},
        '{8'h08, 32'h0000_0005, 3, 14},
        '{8'h08, 32'h0000_0009, 3, 30},
        '{8'h08, 32'h0000_000D, 3, 40}};
    logic [7:0]    duty [3] = '{8'h00, 8'h03, 8'hFF};

    always #2 clk_i = ~clk_i;
    assign ticks = {pwm_clk_en_o, pix_clk_en_o, mem_clk_en_o, bus_clk_en_o};

    lct_pin_clk #(.HALF_NS(20)) prim_src (.clk_o(prim_pin));
    lct_pin_clk #(.HALF_NS(28)) sec_src (.clk_o(sec_pin));

    lct_top uut (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .wb_cyc_i                (wb_cyc),
        .wb_stb_i                (wb_stb),
        .wb_we_i                 (wb_we),
        .wb_adr_i                (wb_adr),
        .wb_sel_i                (wb_sel),
        .wb_dat_i                (wb_wdat),
        .wb_dat_o                (wb_dat_o),
        .wb_ack_o                (wb_ack_o),
        .primary_clock_input_i   (prim_pin),
        .secondary_clock_input_i (sec_pin),
        .bus_clk_en_o            (bus_clk_en_o),
        .mem_clk_en_o            (mem_clk_en_o),
        .pix_clk_en_o            (pix_clk_en_o),
        .pwm_clk_en_o            (pwm_clk_en_o),
        .pwm_output_o            (pwm_output_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc  <= 1'h1;
        wb_stb  <= 1'h1;
        wb_we   <= w;
        wb_adr  <= a;
        wb_sel  <= s;
        wb_wdat <= d;
        // no answer time is assumed; only the watchdog ends a lost answer
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, 4'hF, q);
    endtask

    // cycles spanned by four periods of one rate enable
    task automatic span_of(input int idx, output int span);
        int n;
        n = 0;
        span = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ticks[idx] !== 1'b1 && n < 4000);
        n = 0;
        while (n < 4 && span < 8000) begin
            @(posedge clk_i);
            span++;
            if (ticks[idx] === 1'b1) n++;
        end
    endtask

    // first span is thrown away: a ratio change lands mid-count
    task automatic rate(input int idx, input int per);
        int s;
        span_of(idx, s);
        span_of(idx, s);
        chk(32'(s), 32'(4 * per));
    endtask

    task automatic quiet_pwm();
        int n;
        n = 0;
        repeat (300) begin
            @(posedge clk_i);
            if (pwm_clk_en_o !== 1'b0) n++;
        end
        chk(32'(n), 32'h0000_0000);
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        int          h;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 3; i++) begin
            wb_xfer(1'b0, 8'(4 * i), 32'h0000_0000, 4'hF, q);
            chk(q, 32'h0000_0000);
        end
        chk({31'h0, pwm_output_o}, 32'h0000_0000);
        rate(0, 10);
        quiet_pwm();
        foreach (reg_rows[i]) begin
            wb_xfer(1'b1, reg_rows[i].adr, reg_rows[i].dat, reg_rows[i].sel, q);
            wb_xfer(1'b0, reg_rows[i].adr, 32'h0000_0000, 4'hF, q);
            chk(q, reg_rows[i].exp);
        end
        foreach (rate_rows[i]) begin
            wr(rate_rows[i].adr, rate_rows[i].dat);
            rate(rate_rows[i].idx, rate_rows[i].per);
        end
        foreach (duty[i]) begin
            wr(OFS_PWMCFG, {8'h00, duty[i], 16'h0001});
            repeat (20) @(posedge clk_i);
            h = 0;
            repeat (2560) begin
                @(posedge clk_i);
                if (pwm_output_o === 1'b1) h++;
            end
            chk(32'(h), 32'(10 * duty[i]));
        end
        wr(OFS_PWMCFG, 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        chk({31'h0, pwm_output_o}, 32'h0000_0000);
        quiet_pwm();
        wr(OFS_PWMCFG, 32'h0000_0002);
        repeat (3) @(posedge clk_i);
        chk({31'h0, pwm_output_o}, 32'h0000_0001);
        wr(OFS_PWMCFG, 32'h0000_0003);
        repeat (30) @(posedge clk_i);
        chk({31'h0, pwm_output_o}, 32'h0000_0001);
        wb_xfer(1'h0, OFS_STATUS, 32'h0000_0000, 4'hF, q);
        chk({31'h0, q[ST_PWM_BIT]}, 32'h0000_0001);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, pwm_output_o}, 32'h0000_0000);
        wb_xfer(1'b0, OFS_PWMCFG, 32'h0000_0000, 4'hF, q);
        chk(q, 32'h0000_0000);
        tally_and_finish();
    end

    // the whole sequence needs well under 30000 cycles
    initial begin
        #(60000 * 4);
        num_errors++;
        tally_and_finish();
    end
endmodule
